/* hw/svc_jtag_pkg.sv */
`default_nettype none
package svc_jtag_pkg;
   // Instruction codes handled here
   localparam logic [4:0] IR_WORD   = 5'h11;
   localparam logic [4:0] IR_BLOCK  = 5'h12;
   localparam logic [4:0] IR_CANCEL = 5'h13;
   localparam logic [4:0] IR_SYNC   = 5'h17;
   localparam logic [4:0] IR_BYPASS = 5'h1F;
   // Widths
   localparam int IR_W   = 5;
   localparam int SR_W   = 35;
   localparam int ADDR_W = 36;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;
   // Data register lengths per instruction
   localparam int WORD_LEN  = 35;
   localparam int BLOCK_LEN = 34;
   localparam int SYNC_LEN  = 16;
   localparam int BYP_LEN   = 1;
   // Field positions in the shift register
   localparam int STAT_B     = 0;
   localparam int STAT_E     = 1;
   localparam int DIR_POS    = 0;
   localparam int ADDR_LO    = 1;
   localparam int RD_LO      = 2;
   localparam int WR_LO_WORD = 3;
   localparam int WR_LO_BLK  = 2;
   localparam int WA_LSB     = 2;
   // Fixed low bits of the IR capture pattern
   localparam logic [1:0] IR_CAP_FIXED = 2'h1;
   // Access size codes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } tap_state_t;

   // Address advance for one block step
   function automatic logic [ADDR_W-1:0] addr_step(input logic [1:0] size);
      unique case (size)
         SIZE_BYTE: addr_step = 36'h0_0000_0001;
         SIZE_HALF: addr_step = 36'h0_0000_0002;
         default:   addr_step = 36'h0_0000_0004;
      endcase
   endfunction : addr_step

   // Active data register length for an instruction
   function automatic logic [5:0] dr_len(input logic [4:0] ir);
      unique case (ir)
         IR_WORD:  dr_len = 6'(WORD_LEN);
         IR_BLOCK: dr_len = 6'(BLOCK_LEN);
         IR_SYNC:  dr_len = 6'(SYNC_LEN);
         default:  dr_len = 6'(BYP_LEN);
      endcase
   endfunction : dr_len
endpackage : svc_jtag_pkg
`default_nettype wire

/* hw/svc_jtag_access.sv */
`default_nettype none
// Overview of operation
// - Word instruction uses a 35-bit register: direction, 34-bit word address, 32 data.
// - Word access always uses word size; two low address bits are never shifted.
// - Word register starts as address, toggles per data scan started while not busy.
// - Writes carry full 32 data bits; reads may stop shifting early.
// - Address and read scans shift error and busy out first, lowest positions.
// - Block instruction, 34 bits, repeats last operation at address plus 4, as size always stays word.
// - Byte or halfword block access still exchanges a full 32-bit data field.
// - Cancel ends current access soon; one-bit register reading zero.
// - Cancelled transfer reports an error to the debugger.
// - Clock-ratio instruction loads a 16-bit down-counter running on system clock.
// - Busy stays high while that counter is non-zero, shifted out lowest.
// - Capture-IR loads protect, error, busy, then fixed bits 0 and 1.
module svc_jtag_access
   import svc_jtag_pkg::*;
(
   input  wire  logic                      mclk,
   input  wire  logic                      rst_n,
   input  wire  logic                      ce,
   input  wire  logic                      tck,
   input  wire  logic                      tms,
   input  wire  logic                      tdi,
   output logic                            tdo,
   output logic                            tdo_oe,
   input  wire  logic                      prot_bit,
   output logic                            service_access_bus_req,
   output logic                            service_access_bus_write,
   output logic [1:0]                      service_access_bus_size,
   output logic [svc_jtag_pkg::ADDR_W-1:0] service_access_bus_addr,
   output logic [svc_jtag_pkg::DATA_W-1:0] service_access_bus_wdata,
   input  wire  logic [svc_jtag_pkg::DATA_W-1:0] service_access_bus_rdata,
   input  wire  logic                      service_access_bus_ack,
   input  wire  logic                      service_access_bus_err,
   output logic                            service_access_bus_cancel,
   output logic                            busy,
   output logic                            error
);
   import svc_jtag_pkg::*;

   logic              tck_s1, tck_s2, tck_s3;
   logic              tms_s1, tms_s2;
   logic              tdi_s1, tdi_s2;
   logic              tck_rise, tck_fall;
   tap_state_t        tap_q, tap_d;
   logic [IR_W-1:0]   ir_q;
   logic [SR_W-1:0]   sr_q;
   logic              data_phase_q;
   logic              dir_read_q;
   logic              cap_busy_q;
   logic              pend_q;
   logic              err_q;
   logic [DATA_W-1:0] rdata_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [5:0]        len;
   logic              upd_dr, upd_ir, launch_rd, launch_wr;
   logic [ADDR_W-1:0] next_addr;

   // Two-flop synchronisers for the link pins, third stage for edges
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tck_s1 <= 1'b0;
         tck_s2 <= 1'b0;
         tck_s3 <= 1'b0;
         tms_s1 <= 1'b1;
         tms_s2 <= 1'b1;
         tdi_s1 <= 1'b0;
         tdi_s2 <= 1'b0;
      end else if (ce) begin
         tck_s1 <= tck;
         tck_s2 <= tck_s1;
         tck_s3 <= tck_s2;
         tms_s1 <= tms;
         tms_s2 <= tms_s1;
         tdi_s1 <= tdi;
         tdi_s2 <= tdi_s1;
      end
   end

   assign tck_rise = tck_s2 & ~tck_s3;
   assign tck_fall = ~tck_s2 & tck_s3;
   assign len      = dr_len(ir_q);
   assign busy     = pend_q | (cnt_q != CNT_ZERO);
   assign error    = err_q;
   assign upd_dr   = tck_rise && (tap_q == UPD_DR);
   assign upd_ir   = tck_rise && (tap_q == UPD_IR);

   // TAP controller next state
   always_comb begin
      tap_d = tap_q;
      unique case (tap_q)
         TLR:    tap_d = tms_s2 ? TLR : RTI;
         RTI:    tap_d = tms_s2 ? SEL_DR : RTI;
         SEL_DR: tap_d = tms_s2 ? SEL_IR : CAP_DR;
         CAP_DR: tap_d = tms_s2 ? EX1_DR : SH_DR;
         SH_DR:  tap_d = tms_s2 ? EX1_DR : SH_DR;
         EX1_DR: tap_d = tms_s2 ? UPD_DR : PA_DR;
         PA_DR:  tap_d = tms_s2 ? EX2_DR : PA_DR;
         EX2_DR: tap_d = tms_s2 ? UPD_DR : SH_DR;
         UPD_DR: tap_d = tms_s2 ? SEL_DR : RTI;
         SEL_IR: tap_d = tms_s2 ? TLR : CAP_IR;
         CAP_IR: tap_d = tms_s2 ? EX1_IR : SH_IR;
         SH_IR:  tap_d = tms_s2 ? EX1_IR : SH_IR;
         EX1_IR: tap_d = tms_s2 ? UPD_IR : PA_IR;
         PA_IR:  tap_d = tms_s2 ? EX2_IR : PA_IR;
         EX2_IR: tap_d = tms_s2 ? UPD_IR : SH_IR;
         UPD_IR: tap_d = tms_s2 ? SEL_DR : RTI;
      endcase
   end

   // TAP state register, advanced on each TCK rising edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tap_q <= TLR;
      end else if (ce && tck_rise) begin
         tap_q <= tap_d;
      end
   end

   // Instruction register; reset selects bypass
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ir_q <= IR_BYPASS;
      end else if (ce) begin
         if (tck_rise && tap_q == TLR) begin
            ir_q <= IR_BYPASS;
         end else if (upd_ir) begin
            ir_q <= sr_q[IR_W-1:0];
         end
      end
   end

   // Shared capture and shift register, serial data enters at the active top bit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sr_q       <= '0;
         cap_busy_q <= 1'b0;
      end else if (ce && tck_rise) begin
         unique case (tap_q)
            CAP_IR: begin
               sr_q                 <= '0;
               sr_q[IR_W-1:0]       <= {prot_bit, err_q, busy, IR_CAP_FIXED};
            end
            CAP_DR: begin
               sr_q       <= '0;
               cap_busy_q <= busy;
               if (ir_q == IR_WORD || ir_q == IR_BLOCK || ir_q == IR_SYNC) begin
                  sr_q[STAT_B] <= busy;
                  sr_q[STAT_E] <= err_q;
                  if (ir_q != IR_SYNC && (data_phase_q || ir_q == IR_BLOCK) && dir_read_q) begin
                     sr_q[RD_LO +: DATA_W] <= rdata_q;
                  end
               end
               // Cancel and bypass capture a zero
            end
            SH_IR: begin
               sr_q              <= {1'b0, sr_q[SR_W-1:1]};
               sr_q[IR_W-1]      <= tdi_s2;
            end
            SH_DR: begin
               sr_q              <= {1'b0, sr_q[SR_W-1:1]};
               sr_q[len - 6'd1]  <= tdi_s2;
            end
            default: ;
         endcase
      end
   end

   // TDO changes on the falling edge of TCK and drives only while shifting
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (ce && tck_fall) begin
         tdo    <= sr_q[0];
         tdo_oe <= (tap_q == SH_DR) || (tap_q == SH_IR);
      end
   end

   // Decode of the accesses launched from an update
   assign next_addr = service_access_bus_addr + addr_step(service_access_bus_size);
   assign launch_rd = (upd_dr && ir_q == IR_WORD && !cap_busy_q && !data_phase_q
                       && sr_q[DIR_POS])
                    || (upd_dr && ir_q == IR_BLOCK && !cap_busy_q && dir_read_q)
                    || (upd_ir && sr_q[IR_W-1:0] == IR_BLOCK && !busy && dir_read_q);
   assign launch_wr = upd_dr && !cap_busy_q && !dir_read_q
                    && ((ir_q == IR_WORD && data_phase_q) || ir_q == IR_BLOCK);

   // Address or data interpretation of the word register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         data_phase_q <= 1'b0;
      end else if (ce) begin
         if (upd_ir) begin
            data_phase_q <= 1'b0;
         end else if (upd_dr && ir_q == IR_WORD && !cap_busy_q) begin
            data_phase_q <= ~data_phase_q;
         end
      end
   end

   // Bus address, size, direction and write data
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         service_access_bus_addr  <= '0;
         service_access_bus_size  <= SIZE_WORD;
         service_access_bus_wdata <= '0;
         dir_read_q               <= 1'b1;
      end else if (ce) begin
         if (upd_dr && ir_q == IR_WORD && !cap_busy_q && !data_phase_q) begin
            service_access_bus_addr  <= {sr_q[ADDR_LO +: ADDR_W-WA_LSB], 2'h0};
            service_access_bus_size  <= SIZE_WORD;
            dir_read_q               <= sr_q[DIR_POS];
         end else if (launch_wr && ir_q == IR_WORD) begin
            service_access_bus_wdata <= sr_q[WR_LO_WORD +: DATA_W];
         end else if (launch_wr || launch_rd) begin
            service_access_bus_addr  <= next_addr;
            if (launch_wr) begin
               service_access_bus_wdata <= sr_q[WR_LO_BLK +: DATA_W];
            end
         end
      end
   end

   // Bus request, completion, cancel and error status
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q                    <= 1'b0;
         service_access_bus_req    <= 1'b0;
         service_access_bus_write  <= 1'b0;
         service_access_bus_cancel <= 1'b0;
         err_q                     <= 1'b0;
         rdata_q                   <= '0;
      end else if (ce) begin
         service_access_bus_cancel <= 1'b0;
         if (upd_ir && sr_q[IR_W-1:0] == IR_CANCEL && pend_q) begin
            pend_q                    <= 1'b0;
            service_access_bus_req    <= 1'b0;
            service_access_bus_cancel <= 1'b1;
            err_q                     <= 1'b1;
         end else if (pend_q && service_access_bus_ack) begin
            pend_q                 <= 1'b0;
            service_access_bus_req <= 1'b0;
            if (service_access_bus_err) begin
               err_q <= 1'b1;
            end
            if (!service_access_bus_write) begin
               rdata_q <= service_access_bus_rdata;
            end
         end else if (launch_rd || launch_wr) begin
            pend_q                   <= 1'b1;
            service_access_bus_req   <= 1'b1;
            service_access_bus_write <= launch_wr;
            err_q                    <= 1'b0;
         end
      end
   end

   // Clock-ratio down-counter on the system clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= CNT_ZERO;
      end else if (ce) begin
         if (upd_dr && ir_q == IR_SYNC) begin
            cnt_q <= sr_q[CNT_W-1:0];
         end else if (cnt_q != CNT_ZERO) begin
            cnt_q <= cnt_q - 16'h0001;
         end
      end
   end

endmodule : svc_jtag_access
`default_nettype wire

/* hw/unused_marker.sv */
`default_nettype none
`default_nettype wire

/* test/svc_jtag_properties.sv */
`default_nettype none
module svc_jtag_checker
   import svc_jtag_pkg::*;
(
   input wire logic                 mclk,
   input wire logic                 rst_n,
   input wire logic                 service_access_bus_req,
   input wire logic [1:0]           service_access_bus_size,
   input wire logic [ADDR_W-1:0]    service_access_bus_addr,
   input wire logic                 service_access_bus_ack,
   input wire logic                 service_access_bus_err,
   input wire logic                 service_access_bus_cancel,
   input wire logic                 busy,
   input wire logic                 error
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Bus request, cancel and status relations
   req_busy_a: assert property (service_access_bus_req |-> busy)
      else $error("request pending without busy");
   cancel_drop_a: assert property (service_access_bus_cancel |-> !service_access_bus_req)
      else $error("request still up at cancel");
   cancel_err_a: assert property (service_access_bus_cancel |-> ##[0:1] error)
      else $error("cancel without error status");
   cancel_pulse_a: assert property (service_access_bus_cancel |=> !service_access_bus_cancel)
      else $error("cancel pulse too long");
   ack_err_a: assert property (service_access_bus_req && service_access_bus_ack
      && service_access_bus_err |=> error)
      else $error("failed access left no error");
   ack_done_a: assert property (service_access_bus_req && service_access_bus_ack
      |=> !service_access_bus_req)
      else $error("request held after ack");
   addr_hold_a: assert property (service_access_bus_req ##1 service_access_bus_req
      |-> $stable(service_access_bus_addr))
      else $error("address moved during access");
   word_align_a: assert property (service_access_bus_req && service_access_bus_size == SIZE_WORD
      |-> service_access_bus_addr[1:0] == 2'b00)
      else $error("word access not aligned");
   launch_clr_a: assert property ($rose(service_access_bus_req) |-> ##[0:1] !error)
      else $error("error kept over new access");
endmodule : svc_jtag_checker
bind svc_jtag_access svc_jtag_checker u_svc_jtag_checker (.mclk, .rst_n,
   .service_access_bus_req, .service_access_bus_size, .service_access_bus_addr,
   .service_access_bus_ack, .service_access_bus_err, .service_access_bus_cancel, .busy, .error);
`default_nettype wire

/* test/jtag_dbg_model.sv */
`default_nettype none
module jtag_dbg_model (
   input  wire logic mclk,
   input  wire logic tdo,
   output var  logic tck,
   output var  logic tms,
   output var  logic tdi
);
   timeunit 1ns;
   timeprecision 1ns;
   // TCK stands low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One 400 ns TCK period; TDO is taken just before the rise
   task automatic step(input logic m, input logic d, output logic o);
      @(posedge mclk);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge mclk);
      o = tdo;
      tck <= 1'b1;
      repeat (3) @(posedge mclk);
      tck <= 1'b0;
   endtask : step
   // Idle to idle scan of len bits, LSB first; ir picks the instruction path
   task automatic scan(input logic ir, input int len, input logic [34:0] din,
                       output logic [34:0] dout);
      logic o;
      dout = '0;
      step(1'b1, 1'b0, o);
      if (ir) step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
      // Every bit the caller asks for is shifted
      for (int i = 0; i < len; i++) begin
         step(i == len - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
   endtask : scan
endmodule : jtag_dbg_model
`default_nettype wire

/* test/test_svc_jtag_access.sv */
`default_nettype none
module test_svc_jtag_access;
   import svc_jtag_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, rst_n, ce, prot_bit, tck, tms, tdi, tdo;
   logic        req, wr, ack, berr, cncl, busy, error, stall, berr_en, oe;
   logic [1:0]  sz;
   logic [35:0] addr, acc_addr, ba;
   logic [31:0] wdata, rdata, acc_wd;
   logic [34:0] q;
   logic        acc_wr;
   int          n_acc = 0, wt = 0, n_fail, num_checks, k, c;
   svc_jtag_access u_svc_jtag_access (.mclk(mclk), .rst_n(rst_n), .ce(ce), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(oe), .prot_bit(prot_bit),
      .service_access_bus_req(req), .service_access_bus_write(wr),
      .service_access_bus_size(sz), .service_access_bus_addr(addr),
      .service_access_bus_wdata(wdata), .service_access_bus_rdata(rdata),
      .service_access_bus_ack(ack), .service_access_bus_err(berr),
      .service_access_bus_cancel(cncl), .busy(busy), .error(error));
   jtag_dbg_model u_jtag_dbg_model (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
   // 20 MHz system clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   function automatic logic [31:0] rd(input logic [35:0] a);
      rd = a[31:0] ^ 32'h5A5A_0F0F;
   endfunction : rd
   // Bus responder: ack three cycles into a request unless stalled; records each access
   always @(posedge mclk) begin
      ack <= 1'b0;
      berr <= 1'b0;
      rdata <= ~rd(addr);
      wt <= 0;
      if (req && !ack) begin
         wt <= wt + 1;
         if (wt == 2 && !stall) begin
            ack <= 1'b1;
            berr <= berr_en;
            rdata <= rd(addr);
         end
      end
      if (req && ack) begin
         acc_addr <= addr;
         acc_wr <= wr;
         acc_wd <= wdata;
         n_acc <= n_acc + 1;
      end
   end
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Waits for the access after count kk, then one settling edge
   task automatic acc(input int kk);
      for (int i = 0; i < 200 && n_acc == kk; i++) @(posedge mclk);
      @(posedge mclk);
      chk(n_acc, kk + 1);
   endtask : acc
   task automatic sc(input logic ir, input int len, input logic [34:0] din);
      u_jtag_dbg_model.scan(ir, len, din, q);
      // Outputs launched by the update edge are looked at once settled
      @(negedge mclk);
   endtask : sc
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   // Watchdog
   initial begin
      repeat (60000) @(posedge mclk);
      n_fail++;
      close_out();
   end
   // Test sequence
   initial begin
      {rst_n, stall, berr_en, n_fail, num_checks} = '0;
      {ce, prot_bit} = 2'b11;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk(sz, SIZE_WORD);
      // Leave Test-Logic-Reset for Run-Test/Idle before the first scan
      u_jtag_dbg_model.step(1'b0, 1'b0, q[0]);
      sc(1, 5, 35'(IR_WORD));
      chk(q[4:0], 5'h11);
      sc(0, 35, {34'h2_1234_5678, 1'b0});
      chk({q[1:0], req}, 3'h0);
      k = n_acc;
      sc(0, 35, {32'hC0DE_1234, 3'h0});
      acc(k);
      chk({acc_wr, acc_addr, acc_wd}, {1'b1, 36'h8_48D1_59E0, 32'hC0DE_1234});
      chk(oe, 1'b0);
      $display("word write done");
      ba = 36'h2_0000_0040;
      k = n_acc;
      sc(0, 35, {ba[35:2], 1'b1});
      acc(k);
      chk({acc_wr, acc_addr}, {1'b0, ba});
      sc(0, 35, '0);
      chk(q[33:0], {rd(ba), 2'b00});
      $display("word read done");
      k = n_acc;
      sc(1, 5, 35'(IR_BLOCK));
      acc(k);
      chk(acc_addr, ba + 36'h0_0000_0004);
      berr_en <= 1'b1;
      sc(0, 34, '0);
      chk(q[33:2], rd(ba + 36'h0_0000_0004));
      acc(k + 1);
      chk({acc_addr, error}, {ba + 36'h0_0000_0008, 1'b1});
      berr_en <= 1'b0;
      stall <= 1'b1;
      $display("block read done");
      sc(1, 5, 35'(IR_WORD));
      sc(0, 35, {ba[35:2], 1'b1});
      chk({req, busy}, 2'b11);
      sc(1, 5, 35'(IR_CANCEL));
      chk(q[4:0], 5'h15);
      chk({req, busy, error}, 3'b001);
      sc(0, 1, 35'h7_FFFF_FFFF);
      chk(q[0], 1'b0);
      stall <= 1'b0;
      $display("cancel done");
      sc(1, 5, 35'(IR_SYNC));
      sc(0, 16, 35'h0_0000_0400);
      chk(busy, 1'b1);
      for (c = 0; c < 3000 && busy === 1'b1; c++) @(negedge mclk);
      chk(c >= 1024 - 24 && c <= 1024, 1'b1);
      sc(0, 16, '0);
      chk(q[1:0], 2'b10);
      $display("sync done");
      close_out();
   end
endmodule : test_svc_jtag_access
`default_nettype wire
